// File: src/gpm_defines.svh
// Offsets, field positions, reset values, characters and field depth for the mode block
`ifndef GPM_DEFINES_SVH
`define GPM_DEFINES_SVH
`define GPM_REG_CFG 4'h0
`define GPM_REG_CMD_KEY 4'h1
`define GPM_REG_STATUS 4'h2
`define GPM_REG_FIELD 4'h3
`define GPM_REG_BUS_RX 4'h4
`define GPM_CFG_MODE_LSB 0
`define GPM_CFG_TERM_LSB 2
`define GPM_CFG_ADDR_LSB 4
`define GPM_ADDR_MAX 5'h1e
`define GPM_MODE_RESET 2'h2
`define GPM_TERM_RESET 2'h0
`define GPM_ADDR_RESET 5'h00
`define GPM_CHAR_CR 8'h0d
`define GPM_CHAR_LF 8'h0a
`define GPM_CHAR_SPACE 8'h20
`define GPM_KEY_DELETE 8'h7f
`define GPM_FIELD_DEPTH 8
`endif

// File: src/gpm_pkg.sv
// Types shared by the mode and record-entry block
package gpm_pkg;
	typedef enum logic [1:0] {
		GPM_TALK_LISTEN = 2'b00,
		GPM_TALK_ONLY = 2'b01,
		GPM_LISTEN_ONLY = 2'b10
	} gpm_mode_e;
	typedef enum logic [1:0] {
		GPM_TERM_CRLF = 2'b00,
		GPM_TERM_CRLF_EOI = 2'b01,
		GPM_TERM_CR = 2'b10,
		GPM_TERM_CR_EOI = 2'b11
	} gpm_term_e;
	typedef struct packed {
		logic [4:0] addr;
		gpm_term_e term;
		gpm_mode_e mode;
	} gpm_cfg_s;
	typedef struct packed {
		logic valid;
		logic [7:0] data;
		logic eoi;
	} gpm_byte_s;
	typedef enum logic [1:0] {
		GPM_TX_IDLE = 2'b00,
		GPM_TX_CR = 2'b01,
		GPM_TX_LF = 2'b10
	} gpm_tx_e;
endpackage : gpm_pkg

// File: src/gpm_cmd_field.sv
// Eight-character local command-entry field with oldest-first eviction
`timescale 1ns/1ps
`include "gpm_defines.svh"
module gpm_cmd_field #(
	parameter int DEPTH = `GPM_FIELD_DEPTH
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic enable_in,
	input wire logic key_in,
	input wire logic [7:0] key_char_in,
	input wire logic pop_in,
	output logic [7:0] head_out,
	output logic [3:0] count_out,
	output logic process_out
);
	if (DEPTH < 1 || DEPTH > 15) begin : g_bad_depth
		$error("gpm_cmd_field: DEPTH 1..15");
	end
	logic [7:0] slot [DEPTH];
	logic [3:0] count;
	logic done;
	logic is_del;
	logic is_space;
	logic push;
	assign is_del = key_char_in == `GPM_KEY_DELETE;
	assign is_space = key_char_in == `GPM_CHAR_SPACE;
	assign push = enable_in && key_in && !is_del && !is_space;
	assign head_out = slot[0];
	assign count_out = count;
	// Slot 0 holds the oldest character; pops and evictions shift down
	genvar i;
	generate
		for (i = 0; i < DEPTH; i++) begin : g_slot
			logic [7:0] above;
			// The top slot has nothing above it and takes zero on a pop
			if (i == DEPTH - 1) begin : g_top
				assign above = 8'h00;
			end else begin : g_mid
				assign above = slot[i + 1];
			end
			always_ff @(posedge clk_in) begin
				if (!rstn_in) begin
					slot[i] <= 8'h00;
				end else if (push && done) begin
					if (i == 0) slot[i] <= key_char_in;
				end else if (push && count == 4'(DEPTH)) begin
					if (i == DEPTH - 1) slot[i] <= key_char_in;
					else slot[i] <= above;
				end else if (push) begin
					if (4'(i) == count) slot[i] <= key_char_in;
				end else if (pop_in) begin
					slot[i] <= above;
				end
			end
		end
	endgenerate
	// Count and the flag that marks a submitted record
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			count <= 4'h0;
			done <= 1'b0;
		end else if (push && done) begin
			count <= 4'h1;
			done <= 1'b0;
		end else if (push) begin
			if (count != 4'(DEPTH)) count <= count + 4'h1;
		end else if (enable_in && key_in && is_del && count != 4'h0) begin
			count <= count - 4'h1;
		end else if (enable_in && key_in && is_space && count != 4'h0) begin
			done <= 1'b1;
		end else if (pop_in && count != 4'h0) begin
			count <= count - 4'h1;
		end
	end
	// Space submits the record; delete drops the newest, so no shift needed
	always_ff @(posedge clk_in) begin
		if (!rstn_in) process_out <= 1'b0;
		else process_out <= enable_in && key_in && is_space && count != 4'h0;
	end
endmodule : gpm_cmd_field

// File: src/gpm_port.sv
// Mode, address, terminator and record-entry logic of the parallel bus port
//
// Contract
// - In talk-and-listen mode the port answers at an address from 0 to 30.
// - After defaults are loaded the mode is listen-only.
// - Talk-only mode disables listening and only transmits.
// - Listen-only mode never transmits but processes every received record.
// - A listener executes records; a talker returns the pending answer.
// - The terminator is one of CR LF, CR LF with EOI, CR, or CR with EOI.
// - The command field is usable only in talk-only mode.
// - The field holds eight characters; extra ones evict the oldest.
// - A space in the field acts as CR and submits the held record.
// - A new record clears the old one; delete removes the newest char.
// - Field records execute as if they came over the bus.
// - In talk-only mode the two memory commands send memory A or B.
// - Settings survive power cycles and a shifted recall keeps them; a cfg write in the same cycle as a shifted recall is not saved.
// - Corrupt parameter memory at power-up reloads the defaults.
// - A listener accepts CR or CR LF as a record end.
`timescale 1ns/1ps
`include "gpm_defines.svh"
module gpm_port #(
	parameter int FIELD_DEPTH = `GPM_FIELD_DEPTH
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	// Register port
	input wire logic [3:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	// Retained settings from battery-backed memory
	input wire logic [8:0] saved_cfg_in,
	input wire logic saved_bad_in,
	input wire logic powerup_done_in,
	input wire logic shift_recall_in,
	output logic [8:0] save_cfg_out,
	output logic save_wr_out,
	// Bus side state
	input wire logic [4:0] bus_addr_in,
	input wire logic bus_listen_cmd_in,
	input wire logic bus_talk_cmd_in,
	input wire logic bus_unaddr_in,
	input wire logic [9:0] bus_rx_in,
	output logic listen_en_out,
	output logic talk_en_out,
	// Records handed to the command executer
	output logic [9:0] exec_out,
	output logic exec_local_out,
	output logic exec_end_out,
	// Talker data source and transmit bytes
	input wire logic [9:0] reply_in,
	output logic reply_ready_out,
	input wire logic tx_ready_in,
	output logic [9:0] tx_out,
	output logic send_mem_a_out,
	output logic send_mem_b_out
);
	// Three slots are the least that still holds a memory command
	if (FIELD_DEPTH < 3 || FIELD_DEPTH > 15) begin : g_bad_depth
		$error("gpm_port: FIELD_DEPTH");
	end
	gpm_pkg::gpm_cfg_s cfg;
	gpm_pkg::gpm_byte_s rx;
	gpm_pkg::gpm_byte_s rep;
	gpm_pkg::gpm_byte_s exec_b;
	gpm_pkg::gpm_byte_s tx_b;
	gpm_pkg::gpm_tx_e tx_state;
	logic loaded;
	logic listened;
	logic talked;
	logic rx_cr;
	logic [7:0] head;
	logic [3:0] fcount;
	logic fprocess;
	logic draining;
	logic pop;
	logic key_wr;
	logic [7:0] m_c;
	logic [7:0] m_m;
	logic [2:0] cmd_hist;
	logic [7:0] last_key;
	logic mode_ok;
	logic key_open;
	assign rx = bus_rx_in;
	assign rep = reply_in;
	assign key_wr = reg_wr_in && reg_addr_in == `GPM_REG_CMD_KEY;
	assign mode_ok = reg_wdata_in[1:0] != 2'b11;
	assign save_cfg_out = cfg;
	// Keys are refused from the submit edge until the drain ends, so a
	// fast key cannot wipe a record before it has been read out
	assign key_open = !draining && !fprocess;
	////////////////////////////////////////////////////////////////////////
	// Settings: loaded once from retained memory, defaults if it is bad
	// A refused write changes neither cfg nor the retained copy
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			cfg <= {`GPM_ADDR_RESET, `GPM_TERM_RESET, `GPM_MODE_RESET};
			loaded <= 1'b0;
			save_wr_out <= 1'b0;
		end else begin
			save_wr_out <= 1'b0;
			if (!loaded && powerup_done_in) begin
				loaded <= 1'b1;
				if (saved_bad_in) begin
					cfg <= {`GPM_ADDR_RESET, `GPM_TERM_RESET,
						`GPM_MODE_RESET};
					save_wr_out <= 1'b1;
				end else if (saved_cfg_in[1:0] != 2'b11 &&
					saved_cfg_in[8:4] <= `GPM_ADDR_MAX) begin
					cfg <= saved_cfg_in;
				end
			end else if (reg_wr_in && reg_addr_in == `GPM_REG_CFG &&
				mode_ok && reg_wdata_in[8:4] <= `GPM_ADDR_MAX) begin
				cfg <= reg_wdata_in[8:0];
				save_wr_out <= 1'b1;
			end
			// Shifted recall leaves cfg untouched on purpose
			if (shift_recall_in) save_wr_out <= 1'b0;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Addressed state; listen-only and talk-only need no address
	// An unaddress pulse wins over a listen or talk command in one cycle
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			listened <= 1'b0;
			talked <= 1'b0;
		end else if (bus_unaddr_in) begin
			listened <= 1'b0;
			talked <= 1'b0;
		end else if (cfg.mode == gpm_pkg::GPM_TALK_LISTEN &&
			bus_addr_in == cfg.addr) begin
			if (bus_listen_cmd_in) begin
				listened <= 1'b1;
				talked <= 1'b0;
			end else if (bus_talk_cmd_in) begin
				talked <= 1'b1;
				listened <= 1'b0;
			end
		end
	end
	// Listener and talker enables per mode
	always_comb begin
		case (cfg.mode)
			gpm_pkg::GPM_TALK_ONLY: begin
				listen_en_out = 1'b0;
				talk_en_out = 1'b1;
			end
			gpm_pkg::GPM_LISTEN_ONLY: begin
				listen_en_out = 1'b1;
				talk_en_out = 1'b0;
			end
			default: begin
				listen_en_out = listened;
				talk_en_out = talked;
			end
		endcase
	end
	////////////////////////////////////////////////////////////////////////
	// Local command field, only fed in talk-only mode
	gpm_cmd_field #(
		.DEPTH(FIELD_DEPTH)
	) u_field (
		.clk_in(clk_in),
		.rstn_in(rstn_in),
		.enable_in(cfg.mode == gpm_pkg::GPM_TALK_ONLY),
		.key_in(key_wr && key_open),
		.key_char_in(reg_wdata_in[7:0]),
		.pop_in(pop),
		.head_out(head),
		.count_out(fcount),
		.process_out(fprocess)
	);
	assign pop = draining && fcount != 4'h0;
	// Drain state: the field is read out one char per cycle, then CR
	// The drain always ends with a CR, so a record is never left open
	always_ff @(posedge clk_in) begin
		if (!rstn_in) draining <= 1'b0;
		else if (fprocess) draining <= 1'b1;
		else if (fcount == 4'h0) draining <= 1'b0;
	end
	////////////////////////////////////////////////////////////////////////
	// Execute stream: local field wins the cycle; bus bytes only if listening
	assign rx_cr = rx.valid && rx.data == `GPM_CHAR_CR;
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			exec_b <= '0;
			exec_local_out <= 1'b0;
			exec_end_out <= 1'b0;
		end else if (pop) begin
			exec_b <= {1'b1, head, 1'b0};
			exec_local_out <= 1'b1;
			exec_end_out <= 1'b0;
		end else if (draining) begin
			exec_b <= {1'b1, `GPM_CHAR_CR, 1'b0};
			exec_local_out <= 1'b1;
			exec_end_out <= 1'b1;
		end else begin
			// LF after CR is passed on but never ends a record twice
			exec_b <= listen_en_out ? rx : '0;
			exec_local_out <= 1'b0;
			exec_end_out <= listen_en_out && rx_cr;
		end
	end
	assign exec_out = exec_b;
	////////////////////////////////////////////////////////////////////////
	// Memory transfer commands recognised from the last three field chars
	// Fixed letters of the two memory commands; the third picks A or B
	assign m_c = 8'h43;
	assign m_m = 8'h4d;
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			cmd_hist <= 3'h0;
			last_key <= 8'h00;
			send_mem_a_out <= 1'b0;
			send_mem_b_out <= 1'b0;
		end else begin
			send_mem_a_out <= 1'b0;
			send_mem_b_out <= 1'b0;
			if (pop) begin
				cmd_hist <= {cmd_hist[1:0], 1'b0};
				if (fcount == 4'h3 && head == m_c) cmd_hist[0] <= 1'b1;
				if (fcount == 4'h2 && cmd_hist[0] && head == m_m)
					cmd_hist[1] <= 1'b1;
				if (fcount == 4'h1 && cmd_hist[1]) last_key <= head;
			end else if (draining) begin
				cmd_hist <= 3'h0;
				if (cfg.mode == gpm_pkg::GPM_TALK_ONLY && cmd_hist[2]) begin
					send_mem_a_out <= last_key == 8'h41;
					send_mem_b_out <= last_key == 8'h42;
				end
			end
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Transmit path: reply bytes, then the selected terminator
	// Reply bytes are taken only while idle, so a terminator is never
	// split by the next reply
	assign reply_ready_out = talk_en_out && tx_state == gpm_pkg::GPM_TX_IDLE
		&& tx_ready_in;
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			tx_state <= gpm_pkg::GPM_TX_IDLE;
			tx_b <= '0;
		end else begin
			tx_b.valid <= 1'b0;
			case (tx_state)
				gpm_pkg::GPM_TX_IDLE: begin
					if (reply_ready_out && rep.valid) begin
						tx_b <= {1'b1, rep.data, 1'b0};
						if (rep.eoi) tx_state <= gpm_pkg::GPM_TX_CR;
					end
				end
				gpm_pkg::GPM_TX_CR: begin
					if (tx_ready_in) begin
						tx_b.valid <= 1'b1;
						tx_b.data <= `GPM_CHAR_CR;
						// EOI goes on the last byte of the terminator
						tx_b.eoi <= cfg.term == gpm_pkg::GPM_TERM_CR_EOI;
						if (cfg.term == gpm_pkg::GPM_TERM_CR ||
							cfg.term == gpm_pkg::GPM_TERM_CR_EOI)
							tx_state <= gpm_pkg::GPM_TX_IDLE;
						else tx_state <= gpm_pkg::GPM_TX_LF;
					end
				end
				gpm_pkg::GPM_TX_LF: begin
					if (tx_ready_in) begin
						tx_b <= {1'b1, `GPM_CHAR_LF,
							cfg.term == gpm_pkg::GPM_TERM_CRLF_EOI};
						tx_state <= gpm_pkg::GPM_TX_IDLE;
					end
				end
				default: tx_state <= gpm_pkg::GPM_TX_IDLE;
			endcase
		end
	end
	assign tx_out = tx_b;
	////////////////////////////////////////////////////////////////////////
	// Register read data, one cycle after the strobe
	// Idle cycles read as zero so a stale word is never taken as an answer
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			reg_rdata_out <= 32'h0;
		end else if (reg_rd_in) begin
			if (reg_addr_in == `GPM_REG_CFG) begin
				reg_rdata_out <= {23'h0, cfg};
			end else if (reg_addr_in == `GPM_REG_STATUS) begin
				reg_rdata_out <= {26'h0, draining, loaded, talked, listened,
					talk_en_out, listen_en_out};
			end else if (reg_addr_in == `GPM_REG_FIELD) begin
				reg_rdata_out <= {20'h0, fcount, head};
			end else if (reg_addr_in == `GPM_REG_BUS_RX) begin
				reg_rdata_out <= {22'h0, exec_b};
			end else begin
				reg_rdata_out <= 32'h0;
			end
		end else begin
			reg_rdata_out <= 32'h0;
		end
	end
endmodule : gpm_port

// File: bench/gpm_port_props.sv
// Concurrent checks on the ports of the parallel bus mode block
`timescale 1ns/1ps
module gpm_port_chk (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic reg_rd_in,
	input wire logic [31:0] reg_rdata_out,
	input wire logic shift_recall_in,
	input wire logic reg_wr_in,
	input wire logic powerup_done_in,
	input wire logic [8:0] save_cfg_out,
	input wire logic listen_en_out,
	input wire logic talk_en_out,
	input wire logic [9:0] bus_rx_in,
	input wire logic [9:0] exec_out,
	input wire logic exec_local_out,
	input wire logic exec_end_out,
	input wire logic send_mem_a_out,
	input wire logic send_mem_b_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	////////////////////////////////////////////////////////////////////
	chk_rd_slot_only: assert property (!$past(reg_rd_in) |->
		reg_rdata_out == 32'h0) else $error("read data off slot");
	chk_addr_in_range: assert property (save_cfg_out[8:4] <= 5'h1e &&
		save_cfg_out[1:0] != 2'h3) else $error("bad cfg");
	chk_lo_no_talk: assert property (save_cfg_out[1:0] ==
		gpm_pkg::GPM_LISTEN_ONLY |-> !talk_en_out)
		else $error("talk in listen-only");
	chk_to_no_listen: assert property (save_cfg_out[1:0] ==
		gpm_pkg::GPM_TALK_ONLY |-> !listen_en_out)
		else $error("listen in talk-only");
	chk_rx_passes: assert property (listen_en_out && bus_rx_in[9] |=>
		exec_out == $past(bus_rx_in)) else $error("rx lost");
	chk_rx_blocked: assert property (!listen_en_out && bus_rx_in[9] &&
		save_cfg_out[1:0] != gpm_pkg::GPM_TALK_ONLY |=> !exec_out[9])
		else $error("rx while unaddressed");
	chk_end_is_cr: assert property (exec_end_out |->
		exec_out[8:1] == 8'h0d) else $error("end without CR");
	chk_mem_a_local: assert property (send_mem_a_out || send_mem_b_out |->
		exec_end_out && exec_local_out) else $error("mem send");
	chk_recall_keeps: assert property (shift_recall_in && !reg_wr_in &&
		!$rose(powerup_done_in) |=> $stable(save_cfg_out))
		else $error("recall changed cfg");
	cov_mem_a: cover property (send_mem_a_out);
	cov_mem_b: cover property (send_mem_b_out);
	cov_bus_end: cover property (exec_end_out && !exec_local_out);
endmodule : gpm_port_chk
bind gpm_port gpm_port_chk u_chk (.clk_in, .rstn_in, .reg_rd_in,
	.reg_rdata_out, .shift_recall_in, .reg_wr_in, .powerup_done_in,
	.save_cfg_out, .listen_en_out, .talk_en_out, .bus_rx_in, .exec_out,
	.exec_local_out, .exec_end_out, .send_mem_a_out, .send_mem_b_out);

// File: bench/gpm_ctl_model.sv
// Bus controller model that takes transmitted bytes with stalls
`timescale 1ns/1ps
module gpm_ctl_model (
	input wire logic clk_in,
	input wire logic [9:0] tx_in,
	output logic tx_ready_out,
	output logic [31:0] got_out,
	output logic [7:0] n_out
);
	initial begin
		tx_ready_out = 1'b0;
		got_out = 32'h0;
		n_out = 8'h0;
	end
	// Ready every other cycle so the talker must wait on a slow listener
	always @(posedge clk_in) begin
		tx_ready_out <= ~tx_ready_out;
		if (tx_in[9]) begin
			got_out <= {got_out[23:0], tx_in[8:1]};
			n_out <= n_out + 8'h1;
		end
	end
endmodule : gpm_ctl_model

// File: bench/testbench.sv
// Register-driven tests of the parallel bus mode block
`timescale 1ns/1ps
module testbench;
	logic clk_in = 0, rstn_in = 0, reg_wr_in = 0, reg_rd_in = 0;
	logic [3:0] reg_addr_in = 0;
	logic [31:0] reg_wdata_in = 0, reg_rdata_out, v, last4 = 0, got;
	logic [8:0] saved_cfg_in = 9'h1ff, save_cfg_out;
	logic saved_bad_in = 1, powerup_done_in = 0, shift_recall_in = 0;
	logic [4:0] bus_addr_in = 0;
	logic lcmd = 0, tcmd = 0, tx_rdy, listen_en_out, talk_en_out;
	logic [9:0] bus_rx_in = 0, reply_in = 0, exec_out, tx_out;
	logic exec_local_out, exec_end_out, mem_a, mem_b, rrdy, save_wr;
	logic [7:0] ntx;
	int mismatches = 0, checks = 0, ends = 0, na = 0, nb = 0, nsave = 0, i;
	always #10 clk_in = ~clk_in;
	gpm_port u_dut (.clk_in, .rstn_in, .reg_addr_in, .reg_wdata_in,
		.reg_wr_in, .reg_rd_in, .reg_rdata_out, .saved_cfg_in,
		.saved_bad_in, .powerup_done_in, .shift_recall_in, .save_cfg_out,
		.save_wr_out(save_wr), .bus_addr_in, .bus_listen_cmd_in(lcmd),
		.bus_talk_cmd_in(tcmd), .bus_unaddr_in(1'b0), .bus_rx_in,
		.listen_en_out, .talk_en_out, .exec_out, .exec_local_out,
		.exec_end_out, .reply_in, .reply_ready_out(rrdy),
		.tx_ready_in(tx_rdy), .tx_out, .send_mem_a_out(mem_a),
		.send_mem_b_out(mem_b));
	gpm_ctl_model u_ctl (.clk_in, .tx_in(tx_out), .tx_ready_out(tx_rdy),
		.got_out(got), .n_out(ntx));
	// Tally record ends and keep the last four local bytes sent to the executer, CR included
	always @(posedge clk_in) begin
		ends <= ends + exec_end_out;
		na <= na + mem_a;
		nb <= nb + mem_b;
		nsave <= nsave + save_wr;
		if (exec_out[9] && exec_local_out)
			last4 <= {last4[23:0], exec_out[8:1]};
	end
	////////////////////////////////////////////////////////////////////
	task stop_test;
		if (mismatches == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : stop_test
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			mismatches++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask : chk
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
		#1;
	endtask : wr
	task rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
		#1 d = reg_rdata_out;
	endtask : rd
	task rx(input logic [7:0] c);
		@(posedge clk_in);
		bus_rx_in <= {1'b1, c, 1'b0};
		@(posedge clk_in);
		bus_rx_in <= 10'h0;
	endtask : rx
	task cmd(input logic [4:0] a, input logic l, input logic t);
		@(posedge clk_in);
		bus_addr_in <= a;
		lcmd <= l;
		tcmd <= t;
		@(posedge clk_in);
		lcmd <= 1'b0;
		tcmd <= 1'b0;
		#1;
	endtask : cmd
	// A wait that runs out counts as a mismatch and ends the run
	task bound(input logic ok);
		if (!ok) begin
			mismatches++;
			stop_test;
		end
	endtask : bound
	task upto(input int n);
		for (i = 0; i < 80 && ends < n; i++)
			@(posedge clk_in);
		bound(ends >= n);
	endtask : upto
	task submit;
		int n;
		n = ends + 1;
		wr(4'h1, 32'h20);
		upto(n);
	endtask : submit
	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge clk_in);
		rstn_in <= 1'b1;
		@(posedge clk_in);
		powerup_done_in <= 1'b1;
		rd(4'h0, v);
		chk("cfg", v, 32'h2);
		rx(8'h4b); rx(8'h0d); rx(8'h0a); rx(8'h4b); rx(8'h0d);
		upto(2);
		chk("ends", ends, 2);
		cmd(5'h0, 1'b0, 1'b1);
		chk("lo", {listen_en_out, talk_en_out}, 2'b10);
		wr(4'h1, 32'h41);
		rd(4'h3, v);
		chk("fld", v, 32'h0);
		wr(4'h0, 32'h3);
		wr(4'h0, 32'h1f0);
		rd(4'h0, v);
		chk("ref", v, 32'h2);
		chk("nsv", nsave, 1);
		for (int t = 0; t < 4; t++) begin
			wr(4'h0, 32'h1e0 | (t << 2));
			rd(4'h0, v);
			chk("term", v, 32'h1e0 | (t << 2));
		end
		@(posedge clk_in) shift_recall_in <= 1'b1;
		@(posedge clk_in) shift_recall_in <= 1'b0;
		rd(4'h0, v);
		chk("rcl", v, 32'h1ec);
		chk("rsv", nsave, 5);
		chk("scf", save_cfg_out, 32'h1ec);
		wr(4'h0, 32'h1e0);
		cmd(5'h1d, 1'b0, 1'b1);
		chk("adr", talk_en_out, 1'b0);
		cmd(5'h1e, 1'b1, 1'b0);
		chk("lsn", listen_en_out, 1'b1);
		rx(8'h53); rx(8'h0d);
		cmd(5'h1e, 1'b0, 1'b1);
		chk("tlk", talk_en_out, 1'b1);
		rd(4'h2, v);
		chk("st", v, 32'h1a);
		@(posedge clk_in) reply_in <= {1'b1, 8'h53, 1'b1};
		for (i = 0; i < 60; i++) begin
			@(negedge clk_in);
			if (rrdy === 1'b1) break;
		end
		bound(i < 60);
		@(posedge clk_in) reply_in <= 10'h0;
		for (i = 0; i < 60 && ntx < 3; i++) @(posedge clk_in);
		bound(ntx >= 3);
		chk("tx", got[23:0], 24'h530d0a);
		wr(4'h0, 32'h1);
		chk("to", {listen_en_out, talk_en_out}, 2'b01);
		for (int k = 0; k < 10; k++) wr(4'h1, 32'h41 + k);
		rd(4'h3, v);
		chk("evict", v, 32'h843);
		wr(4'h1, 32'h7f);
		rd(4'h3, v);
		chk("del", v, 32'h743);
		submit;
		wr(4'h1, 32'h43); wr(4'h1, 32'h4d); wr(4'h1, 32'h41);
		submit;
		chk("rec", last4, 32'h434d410d);
		chk("ma", na, 1);
		wr(4'h1, 32'h43); wr(4'h1, 32'h4d); wr(4'h1, 32'h42);
		submit;
		chk("mb", nb, 1);
		// Power cycle with good retained settings: they come back as saved
		@(posedge clk_in);
		rstn_in <= 1'b0;
		powerup_done_in <= 1'b0;
		saved_bad_in <= 1'b0;
		saved_cfg_in <= 9'h1e5;
		repeat (5) @(posedge clk_in);
		rstn_in <= 1'b1;
		rd(4'h0, v);
		chk("pdef", v, 32'h2);
		@(posedge clk_in) powerup_done_in <= 1'b1;
		rd(4'h0, v);
		chk("keep", v, 32'h1e5);
		chk("pto", {listen_en_out, talk_en_out}, 2'b01);
		chk("psv", nsave, 7);
		stop_test;
	end
endmodule : testbench
